// *** rtl/atf_device.sv ***
// Device end: task file registers, status, command decoder
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// R01: Cylinder high holds block address upper byte
// R02: Host writes ones to obsolete bits
// R03: Bit 6 chooses linear or geometry addressing
// R04: Linear address built from four registers
// R05: Card answers only when unit matches strap
// R06: Low nibble gives head, bit 3 MSB
// R07: Status read in I/O mode drops interrupt; the code drops it only when level_irq_mode is also set
// R08: Busy set while executing; others invalid
// R09: Transfers refused unless ready and seek done
// R10: Write fault sets status bit 5
// R11: Seek done sets status bit 4
// R12: Transfer bit set for data, cleared by command
// R13: Corrected data sets status bit 2
// R14: Status bit 1 always zero
// R15: Error bit set on failure, cleared next command
// R16: Shadow status read keeps interrupt
// R17: Host loads parameters then writes command
// R18: Decode write codes 30/31, C5, CD
// R19: Decode 38, 3C, 32/33
// R20: Only used registers carry parameters
// R21: Power commands use only unit select
// R22: Mask-low bit clear enables interrupt
// R23: Unknown codes abort with error bit
// R24: Command write sets busy, clears error
module atf_device #(
    parameter int EXEC_CYCLES = atf_pkg::EXEC_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    atf_if.device            tf,
    input  wire logic        unit_strap_pin,
    input  wire logic        io_mode,
    input  wire logic        level_irq_mode,
    input  wire logic        write_fault_in,
    input  wire logic        fixed_data_in,
    input  wire logic        seek_done_in,
    output logic [27:0]      linear_address,
    output logic             linear_addressing_select,
    output logic [3:0]       head_select_bits,
    output logic [7:0]       last_opcode,
    output logic             cmd_start
);
    typedef enum logic [1:0] {
        ATF_IDLE = 2'b00,
        ATF_EXEC = 2'b01
    } atf_state_t;

    atf_state_t  state_q;
    logic [7:0]  cyl_high_q, cyl_low_q, sec_num_q, sec_cnt_q, feature_q, unit_hd_q, ctrl_q;
    logic [7:0]  opcode_q;
    logic        busy_flag, device_ready_flag, write_fault_flag, seek_done_flag;
    logic        transfer_request_flag, fixed_data_flag, err_q, irq_pend_q, unit_q;
    logic [1:0]  strap_sync_q;
    logic [7:0]  cnt_q;
    logic        selected, cmd_wr, stat_rd;
    logic [7:0]  status;

    // Known-command decode
    function automatic logic known_cmd(input logic [7:0] c);
        logic k;
        k = 1'b0;
        case (c)
            atf_pkg::CMD_WR_SEC0, atf_pkg::CMD_WR_SEC1, atf_pkg::CMD_WR_MULT, atf_pkg::CMD_WR_MULTNE: k = 1'b1; // [R18]
            atf_pkg::CMD_WR_NOERS, atf_pkg::CMD_WR_VERIFY, atf_pkg::CMD_WR_LONG0, atf_pkg::CMD_WR_LONG1: k = 1'b1; // [R19]
            8'hE5, 8'h98, 8'hE0, 8'h94, 8'hE6, 8'h99, 8'hE2, 8'h96: k = 1'b1; // [R21]
            atf_pkg::CMD_SET_FEAT: k = 1'b1; // [R20]
            8'h90, 8'hC0, 8'h50, 8'hEC, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'h91, 8'hE4, 8'hC4,
            8'h22, 8'h23, 8'h20, 8'h21, 8'h40, 8'h41, 8'h03, 8'hC6, 8'h87, 8'hF5, 8'hE8: k = 1'b1; // [R23]
            default: k = (c[7:4] == 4'h1) || (c[7:4] == 4'h7); // [R23]
        endcase
        return k;
    endfunction

    // Data transfer or seek commands need ready and seek-complete
    function automatic logic media_cmd(input logic [7:0] c);
        return (c[7:4] inside {4'h2, 4'h3, 4'h4, 4'h7}) || (c inside {8'hC4, 8'hC5, 8'hCD});
    endfunction

    // ********
    // Strap synchroniser and selection
    // ********
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_sync_q <= 2'b00;
        end else begin
            strap_sync_q <= {strap_sync_q[0], unit_strap_pin};
        end
    end
    assign unit_q   = strap_sync_q[1];
    assign selected = (unit_hd_q[atf_pkg::BIT_UNIT] == unit_q); // [R05]
    assign cmd_wr   = tf.wr_strobe && !tf.alt_space && tf.addr == atf_pkg::ADDR_STATUS && selected;
    assign stat_rd  = tf.rd_strobe && !tf.alt_space && tf.addr == atf_pkg::ADDR_STATUS && selected;

    // ********
    // Parameter registers
    // ********
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyl_high_q <= 8'h00;
            cyl_low_q  <= 8'h00;
            sec_num_q  <= 8'h01;
            sec_cnt_q  <= 8'h01;
            feature_q  <= 8'h00;
            unit_hd_q  <= atf_pkg::UNIT_HD_RESET;
            ctrl_q     <= atf_pkg::CTRL_RESET;
        end else if (tf.wr_strobe && !busy_flag) begin
            // Unit select is written regardless so either card tracks it
            if (tf.alt_space) begin
                if (tf.addr == atf_pkg::ADDR_CTRL && selected) ctrl_q <= tf.wdata;
            end else begin
                case (tf.addr)
                    atf_pkg::ADDR_CYL_HIGH: if (selected) cyl_high_q <= tf.wdata; // [R01]
                    atf_pkg::ADDR_CYL_LOW:  if (selected) cyl_low_q <= tf.wdata;
                    atf_pkg::ADDR_SEC_NUM:  if (selected) sec_num_q <= tf.wdata;
                    atf_pkg::ADDR_SEC_CNT:  if (selected) sec_cnt_q <= tf.wdata;
                    atf_pkg::ADDR_FEATURE:  if (selected) feature_q <= tf.wdata;
                    atf_pkg::ADDR_UNIT_HD:  unit_hd_q <= tf.wdata; // [R03] [R06]
                    default: ;
                endcase
            end
        end
    end

    assign linear_addressing_select = unit_hd_q[atf_pkg::BIT_LINEAR]; // [R03]
    assign head_select_bits         = unit_hd_q[3:0]; // [R06]
    assign linear_address = {unit_hd_q[3:0], cyl_high_q, cyl_low_q, sec_num_q}; // [R04]

    // ********
    // Command execution and status
    // ********
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q               <= ATF_IDLE;
            busy_flag             <= 1'b0;
            err_q                 <= 1'b0;
            transfer_request_flag <= 1'b0;
            opcode_q              <= 8'h00;
            cnt_q                 <= 8'h00;
            cmd_start             <= 1'b0;
        end else begin
            cmd_start <= 1'b0;
            case (state_q)
                ATF_IDLE: begin
                    if (cmd_wr) begin
                        busy_flag             <= 1'b1; // [R24] [R08]
                        err_q                 <= 1'b0; // [R15] [R24]
                        transfer_request_flag <= 1'b0; // [R12]
                        opcode_q              <= tf.wdata;
                        cnt_q                 <= 8'(EXEC_CYCLES - 1);
                        state_q               <= ATF_EXEC;
                    end
                end
                ATF_EXEC: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        busy_flag <= 1'b0; // [R08]
                        state_q   <= ATF_IDLE;
                        if (!known_cmd(opcode_q) ||
                            (media_cmd(opcode_q) && !(device_ready_flag && seek_done_flag))) begin
                            err_q <= 1'b1; // [R23] [R09]
                        end else begin
                            cmd_start <= 1'b1;
                            transfer_request_flag <= media_cmd(opcode_q) && opcode_q[7:4] != 4'h7
                                                     && opcode_q[7:4] != 4'h4; // [R12]
                        end
                    end
                end
                default: state_q <= ATF_IDLE;
            endcase
        end
    end

    // Status inputs are sampled like any other pin
    logic [2:0] in_s1_q, in_s2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_s1_q <= 3'b000;
            in_s2_q <= 3'b000;
        end else begin
            in_s1_q <= {write_fault_in, fixed_data_in, seek_done_in};
            in_s2_q <= in_s1_q;
        end
    end
    assign write_fault_flag  = in_s2_q[2]; // [R10]
    assign fixed_data_flag   = in_s2_q[1]; // [R13]
    assign seek_done_flag    = in_s2_q[0]; // [R11]
    assign device_ready_flag = !write_fault_flag; // [R09]

    always_comb begin
        status = 8'h00;
        status[atf_pkg::BIT_BUSY]  = busy_flag;
        status[atf_pkg::BIT_RDY]   = device_ready_flag;
        status[atf_pkg::BIT_WF]    = write_fault_flag;
        status[atf_pkg::BIT_SEEK]  = seek_done_flag;
        status[atf_pkg::BIT_XFER]  = transfer_request_flag;
        status[atf_pkg::BIT_FIXED] = fixed_data_flag;
        status[atf_pkg::BIT_INDEX] = 1'b0; // [R14]
        status[atf_pkg::BIT_ERR]   = err_q;
    end

    // ********
    // Read data and interrupt
    // ********
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tf.rdata <= 8'h00;
        end else if (tf.rd_strobe && selected) begin
            if (tf.alt_space) begin
                tf.rdata <= (tf.addr == atf_pkg::ADDR_CTRL) ? status : 8'h00; // [R16]
            end else begin
                case (tf.addr)
                    atf_pkg::ADDR_CYL_HIGH: tf.rdata <= cyl_high_q;
                    atf_pkg::ADDR_CYL_LOW:  tf.rdata <= cyl_low_q;
                    atf_pkg::ADDR_SEC_NUM:  tf.rdata <= sec_num_q;
                    atf_pkg::ADDR_SEC_CNT:  tf.rdata <= sec_cnt_q;
                    atf_pkg::ADDR_UNIT_HD:  tf.rdata <= unit_hd_q;
                    atf_pkg::ADDR_STATUS:   tf.rdata <= status;
                    default:                tf.rdata <= 8'h00;
                endcase
            end
        end
    end

    // Completion sets pending; set wins over a same-cycle status read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_pend_q <= 1'b0;
        end else if (state_q == ATF_EXEC && cnt_q == 8'h00) begin
            irq_pend_q <= 1'b1;
        end else if (stat_rd && io_mode && level_irq_mode) begin
            irq_pend_q <= 1'b0; // [R07]
        end
    end
    assign tf.host_interrupt_request = irq_pend_q && !ctrl_q[atf_pkg::BIT_MASK]; // [R22]
    assign last_opcode = opcode_q;
endmodule

// *** pkg/atf_pkg.sv ***
// Package: task file register addresses, status bits, command codes
package atf_pkg;
    // Register addresses on the task file port
    localparam logic [2:0] ADDR_CYL_LOW  = 3'h4;
    localparam logic [2:0] ADDR_CYL_HIGH = 3'h5;
    localparam logic [2:0] ADDR_UNIT_HD  = 3'h6;
    localparam logic [2:0] ADDR_STATUS   = 3'h7;
    localparam logic [2:0] ADDR_SEC_NUM  = 3'h3;
    localparam logic [2:0] ADDR_FEATURE  = 3'h1;
    localparam logic [2:0] ADDR_SEC_CNT  = 3'h2;
    localparam logic [2:0] ADDR_CTRL     = 3'h6;

    // Status bit positions
    localparam int BIT_BUSY  = 7;
    localparam int BIT_RDY   = 6;
    localparam int BIT_WF    = 5;
    localparam int BIT_SEEK  = 4;
    localparam int BIT_XFER  = 3;
    localparam int BIT_FIXED = 2;
    localparam int BIT_INDEX = 1;
    localparam int BIT_ERR   = 0;

    // Drive/head and control register fields
    localparam int BIT_LINEAR = 6;
    localparam int BIT_UNIT   = 4;
    localparam int BIT_MASK   = 1;

    localparam logic [7:0] UNIT_HD_RESET = 8'hA0;
    localparam logic [7:0] STATUS_RESET  = 8'h50;
    localparam logic [7:0] CTRL_RESET    = 8'h08;

    // Command codes
    localparam logic [7:0] CMD_WR_SEC0   = 8'h30;
    localparam logic [7:0] CMD_WR_SEC1   = 8'h31;
    localparam logic [7:0] CMD_WR_LONG0  = 8'h32;
    localparam logic [7:0] CMD_WR_LONG1  = 8'h33;
    localparam logic [7:0] CMD_WR_NOERS  = 8'h38;
    localparam logic [7:0] CMD_WR_VERIFY = 8'h3C;
    localparam logic [7:0] CMD_WR_MULT   = 8'hC5;
    localparam logic [7:0] CMD_WR_MULTNE = 8'hCD;
    localparam logic [7:0] CMD_SET_FEAT  = 8'hEF;

    // Cycles a command keeps the device busy
    localparam int EXEC_CYCLES = 8;

    // Host register map on AXI4-Lite
    localparam logic [4:0] HREG_CMD    = 5'h00;
    localparam logic [4:0] HREG_STATUS = 5'h04;
    localparam logic [4:0] HREG_RDATA  = 5'h08;
    localparam int HCMD_GO    = 8;
    localparam int HCMD_WRITE = 9;
    localparam int HCMD_ADDR  = 16;
    localparam int HCMD_ALT   = 19;
    localparam int HST_BUSY   = 0;
    localparam int HST_IRQ    = 1;
endpackage

// *** pkg/atf_if.sv ***
// Interface: task file port between host controller and device
`timescale 1ns/100ps
interface atf_if;
    logic       rd_strobe;
    logic       wr_strobe;
    logic       alt_space;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       host_interrupt_request;

    modport device (
        input  rd_strobe, wr_strobe, alt_space, addr, wdata,
        output rdata, host_interrupt_request
    );
    modport host (
        output rd_strobe, wr_strobe, alt_space, addr, wdata,
        input  rdata, host_interrupt_request
    );
endinterface

// *** rtl/atf_host.sv ***
// Host end: AXI4-Lite slave driving the task file port
`timescale 1ns/100ps
module atf_host (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    atf_if.host              tf,
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    logic        aw_q, w_q, busy_q, done_q, irq_s1_q, irq_s2_q;
    logic [4:0]  awa_q;
    logic [31:0] wd_q;
    logic [7:0]  rd_q;
    logic [1:0]  step_q;

    // ********
    // AXI write channel: CMD register starts one task file access
    // ********
    assign awready = !aw_q && !bvalid;
    assign wready  = !w_q && !bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0; w_q <= 1'b0; bvalid <= 1'b0; bresp <= 2'b00;
            awa_q <= 5'h00; wd_q <= 32'h0000_0000;
        end else begin
            if (awvalid && awready) begin aw_q <= 1'b1; awa_q <= awaddr; end
            if (wvalid && wready) begin w_q <= 1'b1; wd_q <= wdata; end
            if (aw_q && w_q && !bvalid) begin
                bvalid <= 1'b1;
                bresp  <= (awa_q == atf_pkg::HREG_CMD && !busy_q) ? 2'b00 : 2'b10;
                aw_q   <= 1'b0;
                w_q    <= 1'b0;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ********
    // Task file access sequencer: strobe one cycle, capture next
    // ********
    logic go;
    assign go = aw_q && w_q && !bvalid && awa_q == atf_pkg::HREG_CMD && !busy_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0; step_q <= 2'b00; done_q <= 1'b0; rd_q <= 8'h00;
            tf.rd_strobe <= 1'b0; tf.wr_strobe <= 1'b0; tf.alt_space <= 1'b0;
            tf.addr <= 3'h0; tf.wdata <= 8'h00;
        end else begin
            tf.rd_strobe <= 1'b0;
            tf.wr_strobe <= 1'b0;
            if (go) begin
                // Parameters go before the opcode; software orders that [R17] [R02]
                busy_q        <= 1'b1;
                done_q        <= 1'b0;
                step_q        <= 2'b01;
                tf.addr       <= wd_q[atf_pkg::HCMD_ADDR +: 3];
                tf.alt_space  <= wd_q[atf_pkg::HCMD_ALT];
                tf.wdata      <= wd_q[7:0];
                tf.wr_strobe  <= wd_q[atf_pkg::HCMD_WRITE];
                tf.rd_strobe  <= !wd_q[atf_pkg::HCMD_WRITE];
            end else if (step_q == 2'b01) begin
                step_q <= 2'b10;
            end else if (step_q == 2'b10) begin
                rd_q   <= tf.rdata;
                busy_q <= 1'b0;
                done_q <= 1'b1;
                step_q <= 2'b00;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_s1_q <= 1'b0; irq_s2_q <= 1'b0;
        end else begin
            irq_s1_q <= tf.host_interrupt_request;
            irq_s2_q <= irq_s1_q;
        end
    end

    // ********
    // AXI read channel
    // ********
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0; rdata <= 32'h0000_0000; rresp <= 2'b00;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= 2'b00;
            case (araddr)
                atf_pkg::HREG_STATUS: rdata <= {29'h0, done_q, irq_s2_q, busy_q};
                atf_pkg::HREG_RDATA:  rdata <= {24'h00_0000, rd_q};
                atf_pkg::HREG_CMD:    rdata <= 32'h0000_0000;
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= 2'b10;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// *** verif/atf_checker_sva.sv ***
// Checker: timing of status, busy window and interrupt on the task file port
`timescale 1ns/100ps
module atf_checker #(
    parameter int EXEC_CYCLES = 8,
    parameter bit STRAP       = 1'b0
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       rd_strobe,
    input wire logic       wr_strobe,
    input wire logic       alt_space,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       host_interrupt_request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ********
    // Shadow of busy window, unit and mask
    // ********
    int   cnt_q;
    logic unit_q;
    logic mask_q;
    logic sel;
    logic st_rd;
    logic cmd_wr;
    logic ctl_wr;
    assign sel    = (unit_q == STRAP);
    assign st_rd  = rd_strobe && !alt_space && addr == atf_pkg::ADDR_STATUS && sel;
    assign cmd_wr = wr_strobe && !alt_space && addr == atf_pkg::ADDR_STATUS && sel;
    assign ctl_wr = wr_strobe && alt_space && addr == atf_pkg::ADDR_CTRL && sel;
    always_ff @(posedge aclk) begin
        if (!aresetn) cnt_q <= 0;
        else if (cmd_wr && cnt_q == 0) cnt_q <= EXEC_CYCLES;
        else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
    // Parameter writes are dropped while busy, so the shadow follows suit
    always_ff @(posedge aclk) begin
        if (!aresetn) unit_q <= atf_pkg::UNIT_HD_RESET[atf_pkg::BIT_UNIT];
        else if (wr_strobe && !alt_space && addr == atf_pkg::ADDR_UNIT_HD && cnt_q == 0) unit_q <= wdata[4];
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) mask_q <= atf_pkg::CTRL_RESET[atf_pkg::BIT_MASK];
        else if (ctl_wr) mask_q <= wdata[atf_pkg::BIT_MASK];
    end
    // ********
    // Assertions
    // ********
    busy_reported_a: assert property (st_rd && cnt_q != 0 |=> rdata[7])
        else $error("busy missing in status");
    idle_reported_a: assert property (st_rd && cnt_q == 0 |=> !rdata[7])
        else $error("busy stuck in status");
    index_zero_a: assert property (rd_strobe && sel && addr == (alt_space ? 3'h6 : 3'h7) |=> !rdata[1])
        else $error("status bit 1 read as one");
    alt_keeps_irq_a: assert property (rd_strobe && alt_space && addr == 3'h6 && host_interrupt_request
        |=> host_interrupt_request)
        else $error("shadow read dropped interrupt");
    mask_blocks_irq_a: assert property (ctl_wr && wdata[1] |=> !host_interrupt_request [*2])
        else $error("interrupt seen while masked");
    irq_rise_cause_a: assert property ($rose(host_interrupt_request)
        |-> $past(cnt_q) == 1 || $past(ctl_wr && !wdata[1]))
        else $error("interrupt rose without cause");
    done_raises_irq_a: assert property (cnt_q == 1 && !mask_q |=> host_interrupt_request)
        else $error("no interrupt on completion");
    irq_fall_cause_a: assert property ($fell(host_interrupt_request)
        |-> $past(st_rd) || $past(cmd_wr) || $past(ctl_wr && wdata[1]))
        else $error("interrupt fell without cause");
    cover property (cmd_wr);
    cover property (st_rd && cnt_q != 0);
    cover property ($fell(host_interrupt_request));
endmodule

// *** verif/ata_task_file_regs_tb.sv ***
// Testbench: host and device ends joined, driven over AXI4-Lite
`timescale 1ns/100ps
module ata_task_file_regs_tb;
    typedef struct packed {logic [31:0] mask; logic [31:0] exp;} atfr_exp_t;
    localparam int EXEC    = 40;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        io_mode, level_irq_mode, write_fault_in, fixed_data_in, seek_done_in;
    logic [27:0] linear_address;
    logic        linear_addressing_select;
    logic [3:0]  head_select_bits;
    logic [7:0]  last_opcode;
    logic        err, xfer;
    int          fail_count, tests_run, cycles, seed;
    atfr_exp_t   e;
    atfr_exp_t   exp_q[$];
    logic [7:0]  codes [18] = '{atf_pkg::CMD_WR_SEC0, atf_pkg::CMD_WR_SEC1, atf_pkg::CMD_WR_LONG0,
        atf_pkg::CMD_WR_LONG1, atf_pkg::CMD_WR_NOERS, atf_pkg::CMD_WR_VERIFY, atf_pkg::CMD_WR_MULT,
        atf_pkg::CMD_WR_MULTNE, atf_pkg::CMD_SET_FEAT, 8'hE5, 8'h98, 8'hE0, 8'h94, 8'h20, 8'hC4, 8'h70, 8'hFF, 8'h02};
    atf_if tf ();
    atf_device #(.EXEC_CYCLES(EXEC)) atf_device_inst (.aclk, .aresetn, .tf(tf.device), .unit_strap_pin(1'b0),
        .io_mode, .level_irq_mode, .write_fault_in, .fixed_data_in, .seek_done_in, .linear_address,
        .linear_addressing_select, .head_select_bits, .last_opcode, .cmd_start());
    atf_host atf_host_inst (.aclk, .aresetn, .tf(tf.host), .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    atf_checker #(.EXEC_CYCLES(EXEC), .STRAP(1'b0)) atf_checker_inst (.aclk, .aresetn,
        .rd_strobe(tf.rd_strobe), .wr_strobe(tf.wr_strobe), .alt_space(tf.alt_space), .addr(tf.addr),
        .wdata(tf.wdata), .rdata(tf.rdata), .host_interrupt_request(tf.host_interrupt_request));
    // ********
    // Checking, bus tasks and closing
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back('{32'h0000_0003, {30'h0, r}});
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
    endtask
    task automatic axi_rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] x, output logic [31:0] d);
        exp_q.push_back('{m, x});
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
    endtask
    task automatic tf_op(input logic w, input logic alt, input logic [2:0] a, input logic [7:0] d);
        logic [31:0] s;
        axi_wr(atf_pkg::HREG_CMD, (32'h1 << atf_pkg::HCMD_GO) | (32'(w) << atf_pkg::HCMD_WRITE)
            | (32'(alt) << atf_pkg::HCMD_ALT) | (32'(a) << atf_pkg::HCMD_ADDR) | 32'(d), 2'b00);
        do axi_rd(atf_pkg::HREG_STATUS, 32'h0, 32'h0, s); while (s[atf_pkg::HST_BUSY] || !s[2]);
    endtask
    task automatic tf_rd(input logic alt, input logic [2:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] d;
        tf_op(1'b0, alt, a, 8'h00);
        axi_rd(atf_pkg::HREG_RDATA, m, x, d);
    endtask
    // Every bus answer pops the oldest note and is checked against it when its mask is nonzero
    always @(posedge aclk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            e = exp_q.pop_front();
            if (e.mask != 32'h0) chk(((rvalid && rready) ? rdata : {30'h0, bresp}) & e.mask, e.exp, "bus answer");
        end
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            $display("mismatch at %0t: run did not finish", $time);
            wrap_up();
        end
    end
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // ********
    // Main sequence
    // ********
    initial begin
        seed = 522;
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        {bready, rready, wstrb} = 6'h3F;
        {io_mode, level_irq_mode, write_fault_in, fixed_data_in, seek_done_in} = 5'b00001;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        tf_rd(0, atf_pkg::ADDR_UNIT_HD, 32'hFF, 32'(atf_pkg::UNIT_HD_RESET));
        tf_rd(0, atf_pkg::ADDR_STATUS, 32'hFF, 32'(atf_pkg::STATUS_RESET));
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            tf_op(1, 0, atf_pkg::ADDR_SEC_NUM, v[7:0]);
            tf_op(1, 0, atf_pkg::ADDR_CYL_LOW, v[15:8]);
            tf_op(1, 0, atf_pkg::ADDR_CYL_HIGH, v[23:16]);
            tf_op(1, 0, atf_pkg::ADDR_UNIT_HD, {1'b1, v[30], 2'b10, v[27:24]});
            tf_rd(0, atf_pkg::ADDR_CYL_HIGH, 32'hFF, 32'(v[23:16]));
            tf_rd(0, atf_pkg::ADDR_UNIT_HD, 32'hFF, {24'h0, 1'b1, v[30], 2'b10, v[27:24]});
            chk(32'(linear_address), 32'(v[27:0]), "block address");
            chk(32'(linear_addressing_select), 32'(v[30]), "addressing select");
            chk(32'(head_select_bits), 32'(v[27:24]), "head bits");
        end
        tf_op(1, 0, atf_pkg::ADDR_UNIT_HD, 8'hB0);
        tf_op(1, 0, atf_pkg::ADDR_CYL_HIGH, ~v[23:16]);
        tf_op(1, 0, atf_pkg::ADDR_UNIT_HD, 8'hA0);
        tf_rd(0, atf_pkg::ADDR_CYL_HIGH, 32'hFF, 32'(v[23:16]));
        $display("test addressing done");
        foreach (codes[i]) begin
            {io_mode, level_irq_mode} <= 2'($random(seed));
            err  = (i >= 16);
            xfer = (i < 8) || i == 13 || i == 14;
            tf_op(1, 0, atf_pkg::ADDR_STATUS, codes[i]);
            tf_rd(0, atf_pkg::ADDR_STATUS, 32'h80, 32'h80);
            repeat (EXEC) @(posedge aclk);
            tf_rd(1, atf_pkg::ADDR_CTRL, 32'h8B, {28'h0, xfer, 2'b00, err});
            chk(32'(last_opcode), 32'(codes[i]), "opcode");
            chk(32'(tf.host_interrupt_request), 32'h1, "irq after shadow read");
            tf_rd(0, atf_pkg::ADDR_STATUS, 32'h0, 32'h0);
            chk(32'(tf.host_interrupt_request), 32'(!(io_mode && level_irq_mode)), "irq after status read");
        end
        $display("test command codes done");
        write_fault_in <= 1'b1;
        repeat (4) @(posedge aclk);
        tf_op(1, 0, atf_pkg::ADDR_STATUS, atf_pkg::CMD_WR_SEC0);
        repeat (EXEC) @(posedge aclk);
        tf_rd(0, atf_pkg::ADDR_STATUS, 32'hE1, 32'h21);
        {write_fault_in, fixed_data_in, seek_done_in} <= 3'b010;
        repeat (4) @(posedge aclk);
        tf_op(1, 0, atf_pkg::ADDR_STATUS, 8'h20);
        repeat (EXEC) @(posedge aclk);
        tf_rd(0, atf_pkg::ADDR_STATUS, 32'hF5, 32'h45);
        {fixed_data_in, seek_done_in} <= 2'b01;
        $display("test fault flags done");
        tf_op(1, 0, atf_pkg::ADDR_STATUS, atf_pkg::CMD_SET_FEAT);
        repeat (EXEC) @(posedge aclk);
        tf_op(1, 1, atf_pkg::ADDR_CTRL, 8'h0A);
        chk(32'(tf.host_interrupt_request), 32'h0, "masked irq");
        tf_op(1, 1, atf_pkg::ADDR_CTRL, 8'h08);
        chk(32'(tf.host_interrupt_request), 32'h1, "unmasked irq");
        axi_wr(atf_pkg::HREG_STATUS, 32'h0, 2'b10);
        axi_rd(5'h0C, 32'h0, 32'h0, v);
        $display("test mask and bus errors done");
        repeat (4) @(posedge aclk);
        wrap_up();
    end
endmodule
